// ---- eeps_defs.svh ----
`ifndef EEPS_DEFS_SVH
`define EEPS_DEFS_SVH

// System clock rate in hertz.
`define EEPS_CLK_HZ 20000000
// Longest nonvolatile program time in milliseconds, standard and lowest supply option.
`define EEPS_NV_PROGRAM_TIME_MS 10
`define EEPS_NV_PROGRAM_TIME_LOW_MS 20
// Width of the program timer, large enough for the lowest supply option.
`define EEPS_PROG_CNT_W 20

// Device address word layout.
`define EEPS_DEV_CODE 5'h14
`define EEPS_DEV_CODE_MSB 7
`define EEPS_DEV_CODE_LSB 3
`define EEPS_SEL_MSB 2
`define EEPS_SEL_LSB 1
`define EEPS_RW_BIT 0

// Word address and data widths.
`define EEPS_ADDR_W 14
`define EEPS_PAGE_W 6
`define EEPS_DATA_W 8
`define EEPS_ADDR_HI_W 6
`define EEPS_ENTRY_W 22

// Bit slot counts within one transferred word.
`define EEPS_BITS_PER_WORD 4'h8
`define EEPS_ACK_SLOT 4'h9

// Reset values.
`define EEPS_RST_ADDR 14'h0000
`define EEPS_RST_BITCNT 4'h0

`endif

// ---- eeps_pkg.sv ----
package eeps_pkg;
  `include "eeps_defs.svh"

  // Bus engine states; standby is the power-up state.
  typedef enum logic [2:0] {
    EEPS_ST_STANDBY,
    EEPS_ST_DEV,
    EEPS_ST_ADRH,
    EEPS_ST_ADRL,
    EEPS_ST_DATA,
    EEPS_ST_SKIP,
    EEPS_ST_PROG
  } eeps_state_e;

  // One buffered write: word address above, data byte below.
  typedef logic [`EEPS_ENTRY_W-1:0] eeps_entry_t;

  // Whole state of the slave in one record.
  typedef struct packed {
    logic                        scl_m;
    logic                        scl_s;
    logic                        scl_d;
    logic                        sda_m;
    logic                        sda_s;
    logic                        sda_d;
    logic [1:0]                  sel_m;
    logic [1:0]                  sel_s;
    logic                        wp_m;
    logic                        wp_s;
    eeps_state_e                 st;
    logic [3:0]                  bit_cnt;
    logic [7:0]                  shreg;
    logic [`EEPS_ADDR_W-1:0]     word_addr;
    logic                        wr_any;
    logic                        pend_commit;
    logic [`EEPS_PROG_CNT_W-1:0] prog_cnt;
    logic                        sda_oe;
    logic                        sda_lvl;
    eeps_entry_t                 q0;
    eeps_entry_t                 q1;
    logic                        v0;
    logic                        v1;
    logic                        commit;
    logic                        abort;
    logic                        busy;
    logic                        standby;
  } eeps_state_s;
endpackage

// ---- eeps_top.sv ----
`timescale 1ns/1ns
`include "eeps_defs.svh"

// Overview of operation
// RULE1: Data changes while the clock is high count only as start or stop.
// RULE2: Falling data with clock high is a start; every command begins with one.
// RULE3: Rising data with clock high is a stop; afterwards the device rests in standby.
// RULE4: Words are eight bits; the device pulls data low in the ninth clock.
// RULE5: Standby at power-up and after a stop once internal work is done.
// RULE6: The master recovers a stuck bus with up to nine clocks then a start.
// RULE7: Five fixed upper bits of the device address word must match first.
// RULE8: Two select bits must equal the two strap pins.
// RULE9: Floating select straps are seen as logic low.
// RULE10: Lowest address bit chooses operation: one reads, zero writes; here a read is acknowledged but no data is driven.
// RULE11: Match is acknowledged; mismatch stays silent and returns to standby.
// RULE12: A high write-protect input inhibits every array write.
// RULE13: A write carries two address bytes then data, each acknowledged; here a data byte that finds the buffer full is refused.
// RULE14: A stop ends the write and starts the timed nonvolatile program cycle.
// RULE15: During programming the bus is ignored and nothing is acknowledged.
// RULE16: A page write takes up to sixty-four bytes, each acknowledged; here a byte that finds both buffer slots full is refused.
// RULE17: Only the low six address bits advance and wrap inside the page.
// RULE18: Polling with a device address is acknowledged only after programming ends.
// RULE19: Fourteen address bits select one byte of 256 pages of 64 bytes.
// RULE20: Data is sampled at clock rise and driven after clock fall.
// RULE21: A low or open write-protect input lets writes proceed.
// RULE22: The top two bits of the first address byte are ignored.
// RULE23: Stop or start in mid-byte of a write aborts without programming.
module eeps_top #(
  parameter int NV_PROGRAM_CYCLES = `EEPS_NV_PROGRAM_TIME_MS * (`EEPS_CLK_HZ / 1000)
) (
  input  wire logic                     clk_sys,
  input  wire logic                     resetn,
  input  wire logic                     scl_in,
  input  wire logic                     sda_in,
  output logic                          sda_out,
  output logic                          sda_oe,
  input  wire logic                     chip_select_strap_lo,
  input  wire logic                     chip_select_strap_hi,
  input  wire logic                     write_protect,
  output logic                          wr_valid,
  input  wire logic                     wr_ready,
  output logic [`EEPS_ADDR_W-1:0]       wr_addr,
  output logic [`EEPS_DATA_W-1:0]       wr_data,
  output logic                          wr_commit,
  output logic                          wr_abort,
  output logic                          nv_busy,
  output logic                          standby
);

  // Program time in system cycles; a longest time, so the division rounds down.
  localparam logic [`EEPS_PROG_CNT_W-1:0] PROG_LOAD = `EEPS_PROG_CNT_W'(NV_PROGRAM_CYCLES);

  eeps_pkg::eeps_state_s r;
  eeps_pkg::eeps_state_s next_r;

  // Compares a device address word against the fixed code and the strap levels.
  function automatic logic dev_match(input logic [7:0] word, input logic [1:0] sel);
    dev_match = (word[`EEPS_DEV_CODE_MSB:`EEPS_DEV_CODE_LSB] == `EEPS_DEV_CODE) && // RULE7
                (word[`EEPS_SEL_MSB:`EEPS_SEL_LSB] == sel); // RULE8
  endfunction

  // Bus conditions are judged only from synchronised, delayed copies of the pins.
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic buf_space;
  logic push;
  eeps_pkg::eeps_entry_t push_word;

  // Next-state logic for the whole slave.
  always_comb begin
    next_r = r;
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    bus_start = 1'b0;
    bus_stop = 1'b0;
    buf_space = 1'b0;
    push = 1'b0;
    push_word = '0;

    // One-cycle event outputs fall back every cycle.
    next_r.commit = 1'b0;
    next_r.abort = 1'b0;

    // Two-stage synchronisers; the first stage feeds only the second.
    next_r.scl_m = scl_in;
    next_r.scl_s = r.scl_m;
    next_r.scl_d = r.scl_s;
    next_r.sda_m = sda_in;
    next_r.sda_s = r.sda_m;
    next_r.sda_d = r.sda_s;
    next_r.sel_m = {chip_select_strap_hi, chip_select_strap_lo}; // RULE9
    next_r.sel_s = r.sel_m;
    next_r.wp_m = write_protect;
    next_r.wp_s = r.wp_m;

    // Clock edges and the two data-while-clock-high conditions.
    scl_rise = r.scl_s & ~r.scl_d;
    scl_fall = ~r.scl_s & r.scl_d;
    bus_start = r.scl_s & r.scl_d & r.sda_d & ~r.sda_s; // RULE2
    bus_stop = r.scl_s & r.scl_d & ~r.sda_d & r.sda_s; // RULE3

    // The receiver drains the head entry; the tail moves up behind it.
    if (r.v0 && wr_ready) begin
      next_r.q0 = r.q1;
      next_r.v0 = r.v1;
      next_r.v1 = 1'b0;
    end
    buf_space = ~next_r.v1;

    // A commit is only announced once every staged byte has been taken.
    if (r.pend_commit && !r.v0 && !r.v1) begin
      next_r.commit = 1'b1; // RULE14
      next_r.pend_commit = 1'b0;
    end

    case (r.st)
      eeps_pkg::EEPS_ST_PROG: begin
        // Inputs stay locked out until the timer runs down, so polls go unanswered.
        next_r.sda_oe = 1'b0; // RULE15 RULE18
        if (r.prog_cnt <= `EEPS_PROG_CNT_W'(1)) begin
          next_r.st = eeps_pkg::EEPS_ST_STANDBY; // RULE5
          next_r.prog_cnt = '0;
        end else begin
          next_r.prog_cnt = r.prog_cnt - `EEPS_PROG_CNT_W'(1);
        end
      end
      default: begin
        if (bus_start) begin
          // A repeated start throws away any staged page.
          if (r.st == eeps_pkg::EEPS_ST_DATA && r.wr_any) begin
            next_r.abort = 1'b1; // RULE23
            next_r.v0 = 1'b0;
            next_r.v1 = 1'b0;
          end
          next_r.st = eeps_pkg::EEPS_ST_DEV;
          next_r.bit_cnt = `EEPS_RST_BITCNT;
          next_r.sda_oe = 1'b0;
          next_r.wr_any = 1'b0;
        end else if (bus_stop) begin
          next_r.sda_oe = 1'b0;
          next_r.bit_cnt = `EEPS_RST_BITCNT;
          next_r.st = eeps_pkg::EEPS_ST_STANDBY; // RULE3 RULE5
          if (r.st == eeps_pkg::EEPS_ST_DATA && r.wr_any) begin
            // The stop's own clock pulse has already shifted one bit in, so one counts as a boundary.
            if (r.bit_cnt <= `EEPS_RST_BITCNT + 4'h1) begin
              // Stop on a word boundary: start the timed program cycle.
              next_r.st = eeps_pkg::EEPS_ST_PROG; // RULE14
              next_r.prog_cnt = PROG_LOAD;
              next_r.pend_commit = 1'b1;
            end else begin
              // Stop inside a word: nothing is programmed.
              next_r.abort = 1'b1; // RULE23
              next_r.v0 = 1'b0;
              next_r.v1 = 1'b0;
            end
          end
          next_r.wr_any = 1'b0;
        end else if (r.st != eeps_pkg::EEPS_ST_STANDBY) begin
          if (scl_rise && r.bit_cnt < `EEPS_BITS_PER_WORD) begin
            // Data bits are taken on the rising clock, MSB first.
            next_r.shreg = {r.shreg[6:0], r.sda_s}; // RULE20 RULE1
            next_r.bit_cnt = r.bit_cnt + 4'h1;
          end else if (scl_rise && r.bit_cnt == `EEPS_BITS_PER_WORD) begin
            next_r.bit_cnt = `EEPS_ACK_SLOT;
          end else if (scl_fall && r.bit_cnt == `EEPS_ACK_SLOT) begin
            // The acknowledge ends after the ninth clock falls.
            next_r.sda_oe = 1'b0; // RULE20
            next_r.bit_cnt = `EEPS_RST_BITCNT;
          end else if (scl_fall && r.bit_cnt == `EEPS_BITS_PER_WORD) begin
            // A whole word is in; the answer goes out after this falling edge.
            case (r.st)
              eeps_pkg::EEPS_ST_DEV: begin
                if (dev_match(r.shreg, r.sel_s)) begin
                  next_r.sda_oe = 1'b1; // RULE11 RULE4
                  if (r.shreg[`EEPS_RW_BIT]) begin
                    next_r.st = eeps_pkg::EEPS_ST_SKIP; // RULE10
                  end else begin
                    next_r.st = eeps_pkg::EEPS_ST_ADRH; // RULE10
                  end
                end else begin
                  // Not ours: stay silent until the next start.
                  next_r.st = eeps_pkg::EEPS_ST_STANDBY; // RULE11
                  next_r.bit_cnt = `EEPS_RST_BITCNT;
                end
              end
              eeps_pkg::EEPS_ST_ADRH: begin
                next_r.word_addr[`EEPS_ADDR_W-1:`EEPS_DATA_W] =
                  r.shreg[`EEPS_ADDR_HI_W-1:0]; // RULE22 RULE19
                next_r.sda_oe = 1'b1; // RULE13
                next_r.st = eeps_pkg::EEPS_ST_ADRL;
              end
              eeps_pkg::EEPS_ST_ADRL: begin
                next_r.word_addr[`EEPS_DATA_W-1:0] = r.shreg; // RULE19
                next_r.sda_oe = 1'b1; // RULE13
                next_r.st = eeps_pkg::EEPS_ST_DATA;
              end
              eeps_pkg::EEPS_ST_DATA: begin
                if (r.wp_s) begin
                  // Protected: the byte is acknowledged but never staged.
                  next_r.sda_oe = 1'b1; // RULE12
                end else if (buf_space) begin
                  push = 1'b1; // RULE21
                  push_word = {r.word_addr, r.shreg};
                  next_r.word_addr[`EEPS_PAGE_W-1:0] =
                    r.word_addr[`EEPS_PAGE_W-1:0] + `EEPS_PAGE_W'(1); // RULE17
                  next_r.wr_any = 1'b1;
                  next_r.sda_oe = 1'b1; // RULE16 RULE4
                end else begin
                  // No room: refuse the byte so the master sees the stall.
                  next_r.sda_oe = 1'b0;
                end
              end
              default: begin
                // Reads are not served here; the word is let pass unanswered.
                next_r.sda_oe = 1'b0;
              end
            endcase
          end
        end
      end
    endcase

    // A staged byte goes to the first free slot after the drain above.
    if (push) begin
      if (!next_r.v0) begin
        next_r.q0 = push_word;
        next_r.v0 = 1'b1;
      end else begin
        next_r.q1 = push_word;
        next_r.v1 = 1'b1;
      end
    end

    // Status flags follow the state the engine is about to enter.
    next_r.busy = (next_r.st == eeps_pkg::EEPS_ST_PROG);
    next_r.standby = (next_r.st == eeps_pkg::EEPS_ST_STANDBY); // RULE5
    next_r.sda_lvl = 1'b0;
  end

  // State register. Bus lines reset high so that release causes no false condition.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
      r.scl_m <= 1'b1;
      r.scl_s <= 1'b1;
      r.scl_d <= 1'b1;
      r.sda_m <= 1'b1;
      r.sda_s <= 1'b1;
      r.sda_d <= 1'b1;
      r.word_addr <= `EEPS_RST_ADDR;
      r.standby <= 1'b1; // RULE5
    end else begin
      r <= next_r;
    end
  end

  // Every output is a field of the state register.
  assign sda_out = r.sda_lvl;
  assign sda_oe = r.sda_oe;
  assign wr_valid = r.v0;
  assign wr_addr = r.q0[`EEPS_ENTRY_W-1:`EEPS_DATA_W];
  assign wr_data = r.q0[`EEPS_DATA_W-1:0];
  assign wr_commit = r.commit;
  assign wr_abort = r.abort;
  assign nv_busy = r.busy;
  assign standby = r.standby;

endmodule // eeps_top

// ---- eeps_properties.sv ----
`timescale 1ns/1ns
`include "eeps_defs.svh"
// Watches the slave's ports; program length is measured by a small counter.
module eeps_checker #(
  parameter int NV_PROGRAM_CYCLES = 50
) (
  input wire logic                    clk_sys,
  input wire logic                    resetn,
  input wire logic                    scl_in,
  input wire logic                    sda_in,
  input wire logic                    sda_out,
  input wire logic                    sda_oe,
  input wire logic                    chip_select_strap_lo,
  input wire logic                    chip_select_strap_hi,
  input wire logic                    write_protect,
  input wire logic                    wr_valid,
  input wire logic                    wr_ready,
  input wire logic [`EEPS_ADDR_W-1:0] wr_addr,
  input wire logic [`EEPS_DATA_W-1:0] wr_data,
  input wire logic                    wr_commit,
  input wire logic                    wr_abort,
  input wire logic                    nv_busy,
  input wire logic                    standby
);
  logic [31:0] busy_cnt;
  // Counts busy cycles so the program time can be judged without long repetitions.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      busy_cnt <= 32'h0;
    end else begin
      busy_cnt <= nv_busy ? busy_cnt + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // The ack pulse covers the whole ninth clock and then ends promptly.
  sequence s_ack_hold; sda_oe [*6]; endsequence
  sequence s_ack_free; ##[0:11] !sda_oe; endsequence
  property p_ack_len; $rose(sda_oe) |-> s_ack_hold ##1 s_ack_free; endproperty
  property p_busy_quiet; nv_busy |-> !sda_oe && !$rose(wr_valid); endproperty
  property p_prog_max; nv_busy |-> busy_cnt <= NV_PROGRAM_CYCLES; endproperty
  property p_prog_min; $fell(nv_busy) |-> busy_cnt + 32'h1 >= NV_PROGRAM_CYCLES; endproperty
  property p_wake; $fell(nv_busy) |-> ##[0:2] standby; endproperty
  property p_stby; standby |-> !nv_busy && !sda_oe; endproperty
  property p_commit; wr_commit |-> nv_busy && !wr_valid ##1 !wr_commit; endproperty
  property p_abort; wr_abort |-> !nv_busy ##1 !nv_busy && !wr_valid && !wr_abort; endproperty
  property p_protect; write_protect && $past(write_protect, 4) |-> !$rose(wr_valid); endproperty
  property p_hold; wr_valid && !wr_ready |=> wr_valid && $stable(wr_addr) && $stable(wr_data);
  endproperty
  a_ack_len: assert property (p_ack_len) else $error("ack pulse length wrong");
  a_busy_quiet: assert property (p_busy_quiet) else $error("bus active in program");
  a_prog_max: assert property (p_prog_max) else $error("program cycle too long");
  a_prog_min: assert property (p_prog_min) else $error("program cycle too short");
  a_wake: assert property (p_wake) else $error("no standby after program");
  a_stby: assert property (p_stby) else $error("activity in standby");
  a_commit: assert property (p_commit) else $error("commit pulse wrong");
  a_abort: assert property (p_abort) else $error("abort pulse wrong");
  a_protect: assert property (p_protect) else $error("protected byte staged");
  a_hold: assert property (p_hold) else $error("stalled entry changed");
endmodule // eeps_checker

bind eeps_top eeps_checker #(.NV_PROGRAM_CYCLES(NV_PROGRAM_CYCLES)) i_chk (
  .clk_sys(clk_sys), .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .chip_select_strap_lo(chip_select_strap_lo),
  .chip_select_strap_hi(chip_select_strap_hi), .write_protect(write_protect),
  .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
  .wr_commit(wr_commit), .wr_abort(wr_abort), .nv_busy(nv_busy), .standby(standby));

// ---- eeps_master_model.sv ----
`timescale 1ns/1ns
// Bus master model; the clock stands still high between frames.
module eeps_master_model (
  input  wire logic clk_sys,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda
);
  // Both lines idle released, which the pull-up reads as high.
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Low phase is six cycles so the slave's ack release lands before the next rise.
  task automatic clk_bit(input logic b, output logic s);
    wt(3); sda <= b;
    wt(3); scl <= 1'b1;
    wt(2); s = sda_line;
    wt(2); scl <= 1'b0;
  endtask
  task automatic start();
    wt(3); sda <= 1'b1;
    wt(3); scl <= 1'b1;
    wt(4); sda <= 1'b0;
    wt(4); scl <= 1'b0;
  endtask
  task automatic stop();
    wt(3); sda <= 1'b0;
    wt(3); scl <= 1'b1;
    wt(4); sda <= 1'b1;
    wt(4);
  endtask
  // Sends a byte most significant bit first and releases data for the ninth clock.
  task automatic xfer(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
    clk_bit(1'b1, s);
    ack = ~s;
  endtask
  // Frees a stuck data line: clocks until data reads high, at most nine times, then starts.
  task automatic recover(output int n);
    logic s;
    n = 0;
    s = 1'b0;
    while (n < 9 && !s) begin
      clk_bit(1'b1, s);
      n++;
    end
    start();
  endtask
endmodule // eeps_master_model

// ---- tb.sv ----
`timescale 1ns/1ns
// Self-checking bench for the two-wire write slave.
module tb;
  localparam int NV = 300;
  logic        clk_sys = 1'b0;
  logic        resetn, sel_lo, sel_hi, write_protect, wr_ready, scl, m_sda, sda_line;
  logic        sda_out, sda_oe, wr_valid, wr_commit, wr_abort, nv_busy, standby;
  logic [13:0] wr_addr;
  logic [7:0]  wr_data;
  logic [21:0] rx[$];
  int          error_cnt = 0, n_tests = 0, n_commit = 0, n_abort = 0;
  // Open-drain data line with pull-up: low while any party pulls it.
  assign sda_line = m_sda & ~(sda_oe & ~sda_out);
  always #25 clk_sys = ~clk_sys;
  // Receiver of the write buffer: logs accepted entries and counts pulses.
  always @(posedge clk_sys) begin
    if (resetn === 1'b1 && wr_valid === 1'b1 && wr_ready === 1'b1) rx.push_back({wr_addr, wr_data});
    if (wr_commit === 1'b1) n_commit++;
    if (wr_abort === 1'b1) n_abort++;
  end
  eeps_top #(.NV_PROGRAM_CYCLES(NV)) i_dut (.clk_sys(clk_sys), .resetn(resetn), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_strap_lo(sel_lo),
    .chip_select_strap_hi(sel_hi), .write_protect(write_protect), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data), .wr_commit(wr_commit),
    .wr_abort(wr_abort), .nv_busy(nv_busy), .standby(standby));
  eeps_master_model i_mst (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda(m_sda));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin error_cnt++; $display("ERROR %s exp %b got %b", nm, e, g); end
  endtask
  task automatic chk_word(input string nm, input logic [21:0] e, input logic [21:0] g);
    n_tests++;
    if (g !== e) begin error_cnt++; $display("ERROR %s exp %h got %h", nm, e, g); end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic send(input logic [7:0] d, input logic e);
    logic a;
    i_mst.xfer(d, a);
    chk_bit($sformatf("ack of %h", d), e, a);
  endtask
  // Stop, then allow the synchroniser latency before looking at the result.
  task automatic stop4();
    i_mst.stop();
    wt(4);
  endtask
  task automatic wait_idle();
    int k;
    for (k = 0; k < 2000 && nv_busy !== 1'b0; k++) wt(1);
    if (k == 2000) begin error_cnt++; $display("ERROR nv_busy exp 0 got 1"); wrap_up(); end
  endtask
  task automatic t_select();
    for (int s = 0; s < 4; s++) begin
      {sel_hi, sel_lo} <= s[1:0];
      i_mst.start(); send({5'h14, s[1:0], 1'b0}, 1'b1);
      stop4(); i_mst.start(); send({5'h14, s[1:0], 1'b1}, 1'b1);
      stop4(); i_mst.start(); send({5'h14, ~s[1:0], 1'b0}, 1'b0);
      stop4(); i_mst.start(); send({5'h15, s[1:0], 1'b0}, 1'b0);
      stop4(); chk_bit("nv_busy", 1'b0, nv_busy);
    end
    {sel_hi, sel_lo} <= 2'b10;
    $display("test select done");
  endtask
  task automatic t_page();
    rx.delete();
    i_mst.start(); send(8'hA4, 1'b1); send(8'hFF, 1'b1); send(8'hFE, 1'b1);
    for (int i = 1; i < 4; i++) send(8'(8'h11 * i), 1'b1);
    stop4(); chk_bit("nv_busy", 1'b1, nv_busy);
    chk_bit("standby", 1'b0, standby);
    i_mst.start(); send(8'hA4, 1'b0);
    stop4(); wait_idle(); wt(2); chk_bit("standby", 1'b1, standby);
    chk_word("entries", 22'h3, 22'(rx.size()));
    chk_word("entry0", {14'h3FFE, 8'h11}, rx[0]);
    chk_word("entry1", {14'h3FFF, 8'h22}, rx[1]);
    chk_word("entry2", {14'h3FC0, 8'h33}, rx[2]);
    chk_word("commits", 22'h1, 22'(n_commit));
    i_mst.start(); send(8'hA4, 1'b1);
    stop4();
    $display("test page done");
  endtask
  task automatic t_protect();
    rx.delete(); write_protect <= 1'b1;
    i_mst.start(); send(8'hA4, 1'b1); send(8'h00, 1'b1); send(8'h10, 1'b1); send(8'h55, 1'b1);
    stop4(); wt(4); chk_bit("nv_busy", 1'b0, nv_busy);
    chk_word("entries", 22'h0, 22'(rx.size()));
    write_protect <= 1'b0;
    $display("test protect done");
  endtask
  task automatic t_stall();
    rx.delete(); wr_ready <= 1'b0;
    i_mst.start(); send(8'hA4, 1'b1); send(8'h01, 1'b1); send(8'h00, 1'b1);
    send(8'hAA, 1'b1); send(8'hBB, 1'b1); send(8'hCC, 1'b0);
    wr_ready <= 1'b1;
    stop4(); wait_idle();
    chk_word("entries", 22'h2, 22'(rx.size()));
    chk_word("entry1", {14'h0101, 8'hBB}, rx[1]);
    chk_word("commits", 22'h2, 22'(n_commit));
    $display("test stall done");
  endtask
  task automatic t_abort();
    logic s;
    i_mst.start(); send(8'hA4, 1'b1); send(8'h02, 1'b1); send(8'h00, 1'b1); send(8'h5A, 1'b1);
    for (int i = 0; i < 4; i++) i_mst.clk_bit(i[0], s);
    stop4(); wt(4); chk_word("aborts", 22'h1, 22'(n_abort));
    chk_bit("nv_busy", 1'b0, nv_busy);
    chk_word("commits", 22'h2, 22'(n_commit));
    $display("test abort done");
  endtask
  // Cuts a frame just before the address acknowledge, so the slave still holds data low.
  task automatic t_recover();
    logic       s;
    logic [7:0] d;
    int         n;
    d = 8'hA4;
    i_mst.start();
    for (int i = 7; i >= 0; i--) i_mst.clk_bit(d[i], s);
    i_mst.recover(n);
    chk_word("recovery clocks", 22'h2, 22'(n));
    send(8'hA4, 1'b1);
    stop4(); chk_bit("nv_busy", 1'b0, nv_busy);
    $display("test recover done");
  endtask
  initial begin
    resetn <= 1'b0; sel_lo <= 1'b0; sel_hi <= 1'b0; write_protect <= 1'b0; wr_ready <= 1'b1;
    wt(6); resetn <= 1'b1; wt(4);
    chk_bit("standby", 1'b1, standby);
    chk_bit("sda_oe", 1'b0, sda_oe);
    t_select(); t_page(); t_protect(); t_stall(); t_abort(); t_recover();
    wrap_up();
  end
endmodule // tb
